// ===== core/rfe_pkg.sv
// constants, register map and types of the frame check and energy block
package rfe_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_SIG_NS = 2000;
    localparam int T_ED_LONG_NS = 128000;
    localparam int T_ED_SHORT_NS = 32000;
    localparam int T_ED_STORE_NS = 140000;
    localparam int SIG_CYC = T_SIG_NS / CLK_PERIOD_NS;
    localparam int ED_LONG_CYC = T_ED_LONG_NS / CLK_PERIOD_NS;
    localparam int ED_SHORT_CYC = T_ED_SHORT_NS / CLK_PERIOD_NS;
    localparam int ED_STORE_CYC = T_ED_STORE_NS / CLK_PERIOD_NS;
    localparam int ED_PROC_CYC = ED_STORE_CYC - ED_LONG_CYC;
    localparam int ED_LONG_SH = 6;
    localparam int ED_SHORT_SH = 4;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [4:0] RSSI_MAX = 5'h1C;
    localparam logic [7:0] ED_RESET = 8'hFF;
    localparam logic [7:0] ED_STEP = 8'h03;
    localparam logic [6:0] RX_MIN_LEN = 7'h02;
    localparam logic [6:0] SEQ_IDX = 7'h02;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_SIG = 4'h1;
    localparam logic [3:0] ADDR_ED = 4'h2;
    localparam int CTRL_CRC_BIT = 0;
    localparam int CTRL_AACK_BIT = 1;
    localparam int CTRL_ARET_BIT = 2;
    localparam int CTRL_HDR_BIT = 3;
    localparam int SIG_CRC_BIT = 7;
    localparam logic [3:0] CTRL_RESET = 4'h1;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_BODY
    } rfe_tx_e;
endpackage : rfe_pkg

// ===== core/rfe_core.sv
// frame check sequence, signal strength and energy detection logic
`timescale 1ns/1ns
// Contract
// - sixteen bit checksum over bytes after length
// - remainder of shifted message, r0 first
// - check every received frame, record valid bit
// - append checksum unless auto bit cleared
// - checksum over N-2 octets, replaces last two
// - acknowledgment frames always get checksum
// - check length two up, update at rx end
// - auto-ack mode drops bad frames silently
// - auto-retry checks ack checksum and sequence
// - five bit strength, 3 dB, capped 28
// - basic mode strength refreshed every 2 us
// - strength zero means below -90 dBm
// - energy averages strength over 128 us
// - high rate auto measurement 32 us
// - write energy register starts manual measurement
// - header starts automatic measurement, no interrupt
// - result stored 140 us after start, 44 us for high rate auto measurement
// - energy value held until next result stored
// - energy register resets FF, range 00-54
// - energy zero at -90 dBm, 1 dB steps
// - manual request outside receive still completes
module rfe_core
    import rfe_pkg::*;
#(
    parameter int ED_LONG = ED_LONG_CYC,
    parameter int ED_SHORT = ED_SHORT_CYC,
    parameter int ED_PROC = ED_PROC_CYC,
    parameter int SIG_PER = SIG_CYC
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic tx_start,
    input wire logic [6:0] tx_len,
    input wire logic tx_ack_frame,
    input wire logic tx_in_valid,
    input wire logic [7:0] tx_in_data,
    output logic tx_in_ready,
    output logic tx_out_valid,
    output logic [7:0] tx_out_data,
    output logic tx_done,
    input wire logic rx_frame_start,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_frame_end,
    input wire logic rx_active,
    input wire logic basic_mode,
    input wire logic [4:0] rssi_raw,
    output logic rx_begin_irq,
    output logic rx_done_irq,
    output logic ack_accept,
    output logic ack_reject,
    output logic measure_done_irq
);
    typedef struct packed {
        logic [3:0] ctrl;
        rfe_tx_e tx_st;
        logic [6:0] tx_len;
        logic [6:0] tx_cnt;
        logic [15:0] tx_crc;
        logic tx_use_crc;
        logic [7:0] tx_seq;
        logic tx_out_valid;
        logic [7:0] tx_out_data;
        logic tx_done;
        logic [6:0] rx_cnt;
        logic [15:0] rx_crc;
        logic [7:0] rx_seq;
        logic crc_valid;
        logic rx_begin;
        logic rx_done;
        logic ack_ok;
        logic ack_bad;
        logic [4:0] rssi;
        logic [6:0] sig_div;
        logic ed_busy;
        logic ed_man;
        logic ed_short;
        logic [13:0] ed_cnt;
        logic [6:0] smp_div;
        logic [6:0] smp_n;
        logic [11:0] ed_sum;
        logic [7:0] ed_level;
        logic meas_done;
        logic [7:0] rdata;
    } rfe_state_s;

    rfe_state_s st_r;
    rfe_state_s st_nxt;

    // bit serial division, first bit is highest order term
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = d[i] ^ r[15];
            r = {r[14:0], 1'b0};
            if (fb) begin
                r = r ^ CRC_POLY;
            end
        end
        return r;
    endfunction : crc_byte

    function automatic logic [7:0] rev8(input logic [7:0] d);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7 - i];
        end
        return r;
    endfunction : rev8

    logic [4:0] rssi_clip;
    logic tx_need_in;
    logic [7:0] tx_cnt_p2;
    logic rx_ok;
    logic man_req;
    logic [6:0] smp_per;
    logic [6:0] smp_max;
    logic [13:0] ed_end;
    logic [11:0] ed_avg;

    assign rssi_clip = (rssi_raw > RSSI_MAX) ? RSSI_MAX : rssi_raw;
    assign tx_cnt_p2 = {1'b0, st_r.tx_cnt} + 8'h02;
    // with checksum on, input needed only for first N-2 octets; without it, for all N
    assign tx_need_in = !st_r.tx_use_crc || (tx_cnt_p2 < {1'b0, st_r.tx_len});
    // no input taken for checksum slots
    assign tx_in_ready = (st_r.tx_st == TX_BODY) && tx_need_in;
    // frames shorter than two fail the check
    assign rx_ok = (st_r.rx_cnt >= RX_MIN_LEN) && (st_r.rx_crc == 16'h0000);
    assign man_req = reg_wr && (reg_addr == ADDR_ED);
    assign smp_per = st_r.ed_short ? 7'(ED_SHORT >> ED_SHORT_SH) : 7'(ED_LONG >> ED_LONG_SH);
    assign smp_max = st_r.ed_short ? 7'(1 << ED_SHORT_SH) : 7'(1 << ED_LONG_SH);
    assign ed_end = st_r.ed_short ? 14'(ED_SHORT + ED_PROC - 1) : 14'(ED_LONG + ED_PROC - 1);
    assign ed_avg = st_r.ed_short ? (st_r.ed_sum >> ED_SHORT_SH) : (st_r.ed_sum >> ED_LONG_SH);

    always_comb begin
        st_nxt = st_r;
        st_nxt.tx_out_valid = 1'b0;
        st_nxt.tx_done = 1'b0;
        st_nxt.rx_begin = 1'b0;
        st_nxt.rx_done = 1'b0;
        st_nxt.ack_ok = 1'b0;
        st_nxt.ack_bad = 1'b0;
        st_nxt.meas_done = 1'b0;

        if (reg_wr && reg_addr == ADDR_CTRL) begin
            st_nxt.ctrl = reg_wdata[3:0];
        end

        case (st_r.tx_st)
            TX_IDLE: begin
                if (tx_start) begin
                    st_nxt.tx_crc = CRC_INIT;
                    st_nxt.tx_cnt = '0;
                    st_nxt.tx_len = tx_len;
                    st_nxt.tx_use_crc = st_r.ctrl[CTRL_CRC_BIT] || tx_ack_frame;
                    if (tx_len == 7'h00) begin
                        st_nxt.tx_done = 1'b1;
                    end else begin
                        st_nxt.tx_st = TX_BODY;
                    end
                end
            end
            TX_BODY: begin
                if (tx_need_in) begin
                    if (tx_in_valid) begin
                        st_nxt.tx_crc = crc_byte(st_r.tx_crc, tx_in_data);
                        st_nxt.tx_out_valid = 1'b1;
                        st_nxt.tx_out_data = tx_in_data;
                        if (st_r.tx_cnt == SEQ_IDX) begin
                            st_nxt.tx_seq = tx_in_data;
                        end
                        st_nxt.tx_cnt = 7'(st_r.tx_cnt + 7'h01);
                        if (7'(st_r.tx_cnt + 7'h01) == st_r.tx_len) begin
                            st_nxt.tx_st = TX_IDLE;
                            st_nxt.tx_done = 1'b1;
                        end
                    end
                end else begin
                    st_nxt.tx_out_valid = 1'b1;
                    if (tx_cnt_p2 == {1'b0, st_r.tx_len}) begin
                        st_nxt.tx_out_data = rev8(st_r.tx_crc[15:8]);
                    end else begin
                        st_nxt.tx_out_data = rev8(st_r.tx_crc[7:0]);
                    end
                    st_nxt.tx_cnt = 7'(st_r.tx_cnt + 7'h01);
                    if (7'(st_r.tx_cnt + 7'h01) == st_r.tx_len) begin
                        st_nxt.tx_st = TX_IDLE;
                        st_nxt.tx_done = 1'b1;
                    end
                end
            end
            default: begin
                st_nxt.tx_st = TX_IDLE;
            end
        endcase

        if (rx_frame_start) begin
            st_nxt.rx_crc = CRC_INIT;
            st_nxt.rx_cnt = '0;
            st_nxt.rx_begin = 1'b1;
        end else if (rx_byte_valid) begin
            // running check over frame and footer
            st_nxt.rx_crc = crc_byte(st_r.rx_crc, rx_byte);
            if (st_r.rx_cnt == SEQ_IDX) begin
                st_nxt.rx_seq = rx_byte;
            end
            if (st_r.rx_cnt != 7'h7F) begin
                st_nxt.rx_cnt = 7'(st_r.rx_cnt + 7'h01);
            end
        end else if (rx_frame_end) begin
            if (st_r.ctrl[CTRL_ARET_BIT]) begin
                if (rx_ok && st_r.rx_seq == st_r.tx_seq) begin
                    st_nxt.ack_ok = 1'b1;
                end else begin
                    st_nxt.ack_bad = 1'b1;
                end
            end
            if (!(st_r.ctrl[CTRL_AACK_BIT] && !rx_ok)) begin
                // valid bit updated with rx end
                st_nxt.crc_valid = rx_ok;
                st_nxt.rx_done = 1'b1;
            end
        end

        // basic mode refresh every 2 us
        if (basic_mode && rx_active) begin
            if (st_r.sig_div >= 7'(SIG_PER - 1)) begin
                st_nxt.sig_div = '0;
                st_nxt.rssi = rssi_clip;
            end else begin
                st_nxt.sig_div = 7'(st_r.sig_div + 7'h01);
            end
        end else begin
            st_nxt.sig_div = '0;
        end

        if (st_r.ed_busy) begin
            st_nxt.ed_cnt = 14'(st_r.ed_cnt + 14'h0001);
            if (st_r.smp_div >= 7'(smp_per - 7'h01)) begin
                st_nxt.smp_div = '0;
                if (st_r.smp_n < smp_max) begin
                    st_nxt.ed_sum = 12'(st_r.ed_sum + {7'h00, rssi_clip});
                    st_nxt.smp_n = 7'(st_r.smp_n + 7'h01);
                end
            end else begin
                st_nxt.smp_div = 7'(st_r.smp_div + 7'h01);
            end
            if (st_r.ed_cnt >= ed_end) begin
                st_nxt.ed_busy = 1'b0;
                // 3 dB steps give 00 to 54
                st_nxt.ed_level = ed_avg[7:0] * ED_STEP;
                if (st_r.ed_man) begin
                    st_nxt.meas_done = 1'b1;
                end
            end
        end

        if (man_req) begin
            if (rx_active) begin
                st_nxt.ed_busy = 1'b1;
                st_nxt.ed_man = 1'b1;
                st_nxt.ed_short = 1'b0;
                st_nxt.ed_cnt = '0;
                st_nxt.smp_div = '0;
                st_nxt.smp_n = '0;
                st_nxt.ed_sum = '0;
            end else begin
                st_nxt.meas_done = 1'b1;
            end
        end else if (rx_frame_start) begin
            st_nxt.ed_busy = 1'b1;
            st_nxt.ed_man = 1'b0;
            st_nxt.ed_short = st_r.ctrl[CTRL_HDR_BIT];
            st_nxt.ed_cnt = '0;
            st_nxt.smp_div = '0;
            st_nxt.smp_n = '0;
            st_nxt.ed_sum = '0;
        end

        st_nxt.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_CTRL: st_nxt.rdata = {4'h0, st_r.ctrl};
                ADDR_SIG: begin
                    st_nxt.rdata = {st_r.crc_valid, 2'b00, st_r.rssi};
                end
                ADDR_ED: st_nxt.rdata = st_r.ed_level;
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_r <= '0;
            st_r.tx_st <= TX_IDLE;
            st_r.ctrl <= CTRL_RESET;
            st_r.ed_level <= ED_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign tx_out_valid = st_r.tx_out_valid;
    assign tx_out_data = st_r.tx_out_data;
    assign tx_done = st_r.tx_done;
    assign rx_begin_irq = st_r.rx_begin;
    assign rx_done_irq = st_r.rx_done;
    assign ack_accept = st_r.ack_ok;
    assign ack_reject = st_r.ack_bad;
    assign measure_done_irq = st_r.meas_done;
endmodule : rfe_core

// ===== testbench/rfe_bb_model.sv
// receive baseband model: frame start, octets, frame end
`timescale 1ns/1ns
module rfe_bb_model (
    input wire logic clk_sys,
    output logic rx_frame_start,
    output logic rx_byte_valid,
    output logic [7:0] rx_byte,
    output logic rx_frame_end
);
    initial begin
        rx_frame_start = 1'b0;
        rx_byte_valid = 1'b0;
        rx_byte = 8'hA5;
        rx_frame_end = 1'b0;
    end
    task send(input logic [7:0] f [8], input int n);
        int i;
        @(posedge clk_sys);
        rx_frame_start <= 1'b1;
        for (i = 0; i < n; i++) begin
            @(posedge clk_sys);
            rx_frame_start <= 1'b0;
            rx_byte_valid <= 1'b1;
            rx_byte <= f[i];
        end
        @(posedge clk_sys);
        rx_frame_start <= 1'b0;
        rx_byte_valid <= 1'b0;
        rx_byte <= ~rx_byte;
        rx_frame_end <= 1'b1;
        @(posedge clk_sys);
        rx_frame_end <= 1'b0;
    endtask : send
endmodule : rfe_bb_model

// ===== testbench/rfe_core_monitor.sv
// port checker of the frame check and energy core
`timescale 1ns/1ns
module rfe_core_monitor
    import rfe_pkg::*;
#(
    parameter int ED_LONG = ED_LONG_CYC,
    parameter int ED_PROC = ED_PROC_CYC
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic tx_in_valid,
    input wire logic [7:0] tx_in_data,
    input wire logic tx_in_ready,
    input wire logic tx_out_valid,
    input wire logic [7:0] tx_out_data,
    input wire logic tx_done,
    input wire logic rx_frame_start,
    input wire logic rx_frame_end,
    input wire logic rx_active,
    input wire logic rx_begin_irq,
    input wire logic rx_done_irq,
    input wire logic ack_accept,
    input wire logic ack_reject,
    input wire logic measure_done_irq
);
    localparam int LIM = ED_LONG + ED_PROC;
    logic [15:0] cnt_r;
    logic ed_wr;
    logic idle_wr;
    assign ed_wr = reg_wr && reg_addr == ADDR_ED;
    assign idle_wr = ed_wr && !rx_active;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_r <= 16'hFFFF;
        end else if ((ed_wr && rx_active) || rx_frame_start) begin
            cnt_r <= 16'h0000;
        end else if (cnt_r != 16'hFFFF) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data without read");
    sig_range_a: assert property (reg_rd && reg_addr == ADDR_SIG |=> reg_rdata[4:0] <= RSSI_MAX && reg_rdata[6:5] == 2'h0)
        else $error("strength out of range");
    ed_range_a: assert property (reg_rd && reg_addr == ADDR_ED |=> reg_rdata <= 8'h54 || reg_rdata == ED_RESET)
        else $error("energy out of range");
    tx_pass_a: assert property (tx_in_valid && tx_in_ready |=> tx_out_valid && tx_out_data == $past(tx_in_data))
        else $error("buffer byte not sent");
    tx_done_last_a: assert property (tx_done |-> tx_out_valid)
        else $error("done without last byte");
    begin_irq_a: assert property (rx_frame_start |=> rx_begin_irq)
        else $error("missing receive start pulse");
    done_irq_a: assert property (rx_done_irq |-> $past(rx_frame_end))
        else $error("receive end pulse misplaced");
    ack_verdict_a: assert property (ack_accept || ack_reject |-> $past(rx_frame_end) && !(ack_accept && ack_reject))
        else $error("ack verdict misplaced");
    idle_req_a: assert property (idle_wr |=> measure_done_irq)
        else $error("idle request not completed");
    meas_time_a: assert property (measure_done_irq |-> $past(idle_wr) || (int'(cnt_r) >= LIM - 2 && int'(cnt_r) <= LIM))
        else $error("measurement done at wrong time");
endmodule : rfe_core_monitor
bind rfe_core rfe_core_monitor #(.ED_LONG(ED_LONG), .ED_PROC(ED_PROC)) u_rfe_core_monitor (.*);

// ===== testbench/radio_fcs_rssi_energy_detect_bench.sv
// self-checking bench of the frame check and energy core
`timescale 1ns/1ns
module radio_fcs_rssi_energy_detect_bench
    import rfe_pkg::*;
;
    logic clk_sys, srst, reg_wr, reg_rd, tx_start, tx_ack_frame, tx_in_valid, rx_active, basic_mode;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, tx_in_data, reg_rdata, tx_out_data, rx_byte;
    logic [6:0] tx_len;
    logic [4:0] rssi_raw;
    logic tx_in_ready, tx_out_valid, tx_done, rx_frame_start, rx_byte_valid, rx_frame_end;
    logic rx_begin_irq, rx_done_irq, ack_accept, ack_reject, measure_done_irq;
    logic [7:0] fr [8];
    logic [7:0] outq [$];
    int fail_count, total_checks, n_done, n_meas, n_acc, n_rej, c0, c1, j;
    rfe_core #(.ED_LONG(640), .ED_SHORT(160), .ED_PROC(60), .SIG_PER(10)) u_rfe_core (.*);
    rfe_bb_model u_rfe_bb_model (.*);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) begin
        n_done += (rx_done_irq === 1'b1);
        n_meas += (measure_done_irq === 1'b1);
        n_acc += (ack_accept === 1'b1);
        n_rej += (ack_reject === 1'b1);
    end
    task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task rc(input string nm, input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(nm, e, reg_rdata);
    endtask : rc
    task mkf(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        logic [15:0] r;
        int i;
        fr = '{a, b, c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        r = 16'h0000;
        for (i = 0; i < 24; i++) begin
            r = (r[0] ^ fr[i / 8][i % 8]) ? (r >> 1) ^ 16'h8408 : r >> 1;
        end
        fr[3] = r[7:0];
        fr[4] = r[15:8];
    endtask : mkf
    task txf(input logic [6:0] n, input logic ak, input int nin, input int ne);
        int i;
        int k;
        logic fin;
        logic tk;
        i = 0;
        fin = 1'b0;
        outq.delete();
        @(posedge clk_sys);
        tx_start <= 1'b1;
        tx_len <= n;
        tx_ack_frame <= ak;
        tx_in_valid <= 1'b1;
        tx_in_data <= fr[0];
        for (k = 0; k < 300 && !fin; k++) begin
            @(negedge clk_sys);
            if (tx_out_valid === 1'b1) outq.push_back(tx_out_data);
            fin = tx_done === 1'b1;
            tk = tx_in_ready === 1'b1;
            @(posedge clk_sys);
            tx_start <= 1'b0;
            if (tk) begin
                i++;
                tx_in_valid <= i < nin;
                tx_in_data <= fr[i];
            end
        end
        chk("tx_count", 8'(ne), 8'(outq.size()));
        for (k = 0; k < outq.size(); k++) chk("tx_byte", fr[k], outq[k]);
    endtask : txf
    task rxs(input int n);
        u_rfe_bb_model.send(fr, n);
        repeat (3) @(posedge clk_sys);
    endtask : rxs
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #1000000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        srst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        tx_start = 1'b0;
        tx_len = 7'h00;
        tx_ack_frame = 1'b0;
        tx_in_valid = 1'b0;
        tx_in_data = 8'h00;
        rx_active = 1'b0;
        basic_mode = 1'b0;
        rssi_raw = 5'h00;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        rc("ctrl", ADDR_CTRL, 8'h01);
        rc("sig", ADDR_SIG, 8'h00);
        rc("energy", ADDR_ED, ED_RESET);
        rc("unmapped", 4'hF, 8'h00);
        wr(ADDR_SIG, 8'hFF);
        rc("sig_ro", ADDR_SIG, 8'h00);
        mkf(8'h02, 8'h00, 8'h6A);
        txf(7'h05, 1'b0, 3, 5);
        wr(ADDR_CTRL, 8'h00);
        txf(7'h05, 1'b1, 3, 5);
        mkf(8'h11, 8'h22, 8'h33);
        txf(7'h03, 1'b0, 3, 3);
        for (j = 0; j < 4; j++) begin
            wr(ADDR_CTRL, {6'h00, j[1], 1'b0});
            mkf(8'h02, 8'h00, 8'h6A);
            fr[4] = fr[4] ^ {7'h00, j[0]};
            c0 = n_done;
            rxs(5);
            chk("rx_done", {7'h00, j != 3}, 8'(n_done - c0));
            rc("crc_valid", ADDR_SIG, {j != 1, 7'h00});
        end
        wr(ADDR_CTRL, 8'h05);
        mkf(8'h02, 8'h00, 8'h6A);
        txf(7'h05, 1'b0, 3, 5);
        c0 = n_acc;
        c1 = n_rej;
        rxs(5);
        mkf(8'h02, 8'h00, 8'h6B);
        rxs(5);
        chk("ack_ok", 8'h01, 8'(n_acc - c0));
        chk("ack_bad", 8'h01, 8'(n_rej - c1));
        @(posedge clk_sys);
        basic_mode <= 1'b1;
        rx_active <= 1'b1;
        rssi_raw <= 5'h11;
        repeat (25) @(posedge clk_sys);
        rc("strength", ADDR_SIG, 8'h91);
        @(posedge clk_sys);
        basic_mode <= 1'b0;
        rssi_raw <= 5'h0A;
        repeat (25) @(posedge clk_sys);
        rc("strength_hold", ADDR_SIG, 8'h91);
        @(posedge clk_sys);
        basic_mode <= 1'b1;
        c0 = n_meas;
        wr(ADDR_ED, 8'h5A);
        repeat (690) @(posedge clk_sys);
        chk("early_done", 8'h00, 8'(n_meas - c0));
        repeat (20) @(posedge clk_sys);
        chk("manual_done", 8'h01, 8'(n_meas - c0));
        rc("manual_level", ADDR_ED, 8'h1E);
        @(posedge clk_sys);
        rx_active <= 1'b0;
        c0 = n_meas;
        wr(ADDR_ED, 8'h00);
        repeat (3) @(posedge clk_sys);
        chk("idle_done", 8'h01, 8'(n_meas - c0));
        rc("idle_level", ADDR_ED, 8'h1E);
        @(posedge clk_sys);
        rx_active <= 1'b1;
        rssi_raw <= 5'h14;
        c0 = n_meas;
        rxs(0);
        repeat (720) @(posedge clk_sys);
        chk("auto_irq", 8'h00, 8'(n_meas - c0));
        rc("auto_level", ADDR_ED, 8'h3C);
        wr(ADDR_CTRL, 8'h09);
        rssi_raw <= 5'h1F;
        rxs(0);
        repeat (190) @(posedge clk_sys);
        rc("fast_early", ADDR_ED, 8'h3C);
        repeat (30) @(posedge clk_sys);
        rc("fast_level", ADDR_ED, 8'h54);
        rc("strength_clip", ADDR_SIG, 8'h1C);
        report_and_stop();
    end
endmodule : radio_fcs_rssi_energy_detect_bench
